// *** rtl/dcl_params.svh ***
// Purpose: Constants for the single-wire debug command layer.
// Assumes: pclk (40 MHz) is the serial-interface clock.
// Notes:   Offsets, field positions, timing counts and the illegal-answer byte.
`ifndef DCL_PARAMS_SVH
`define DCL_PARAMS_SVH
`define DCL_OFF_CSR        12'h000
`define DCL_OFF_STATE      12'h004
`define DCL_CSR_ILLEGAL    0
`define DCL_CSR_NO_RESPONSE_FLAG     2
`define DCL_CSR_CYCLE_SELECT_A      3
`define DCL_CSR_HANDSHAKE  4
`define DCL_CSR_UNSECURE   5
`define DCL_CSR_HALTED     6
`define DCL_CSR_ENABLE     7
`define DCL_BIT_CYC        5'd16
`define DCL_SAMPLE_CYC     5'd10
`define DCL_TX_LOW1        5'd4
`define DCL_TX_LOW0        5'd12
`define DCL_DLY_CYC        8'd16
`define DCL_DACK_CYC       8'd32
`define DCL_ACK_CYC        8'd16
`define DCL_LONG_ACK_CYC   8'd64
`define DCL_CYCLE_SELECT_A_TIMEOUT  10'd512
`define DCL_SYNC_MIN       8'd128
`define DCL_SYNC_PULSE     8'd128
`define DCL_ILLEGAL_BYTE   8'hee
`endif

// *** rtl/dcl_pkg.sv ***
// Purpose: Types of the single-wire debug command layer.
// Assumes: Constants live in dcl_params.svh.
// Notes:   Request bundles travel as packed structs.
package dcl_pkg;
  typedef enum logic [3:0] {S_IDLE, S_OPC, S_DEC, S_ADDR, S_WDATA, S_DLY, S_ACK, S_TX,
                            S_SYNC_REL, S_SYNC_GAP, S_SYNC_PULSE} dcl_state_t;
  typedef enum logic [1:0] {C_ALWAYS, C_NONINTR, C_ACTIVE, C_NONE} dcl_class_t;
  typedef enum logic [4:0] {K_NOP, K_ACKOFF, K_ACKON, K_BGND, K_RCSR, K_WCSR, K_ERASE, K_RMEM,
                            K_DUMP, K_RSAME, K_WMEM, K_FILL, K_RREG, K_WREG, K_GO, K_STEP,
                            K_BAD} dcl_kind_t;
  // Memory bus request toward the core bus
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  size;
    logic [23:0] addr;
    logic [31:0] wdata;
  } dcl_mem_req_t;
  // Core register request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  index;
    logic [31:0] wdata;
  } dcl_cpu_req_t;
endpackage

// *** rtl/dcl_top.sv ***
// Purpose: Command layer of a single-wire debug controller with APB status access.
// Assumes: Line idles high; host opens each received bit with a falling edge.
// Notes:   Device answers with own falling edges; bit low 4 cycles for one, 12 for zero.
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "dcl_params.svh"
module dcl_top (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  single_wire_in,
  output logic                       single_wire_out,
  output logic                       single_wire_oe,
  input  wire logic                  unsecure,
  input  wire logic                  cpu_halted,
  input  wire logic                  bus_free,
  output dcl_pkg::dcl_mem_req_t      mem_req,
  input  wire logic                  mem_ack,
  input  wire logic [31:0]           mem_rdata,
  output dcl_pkg::dcl_cpu_req_t      cpu_req,
  input  wire logic                  cpu_ack,
  input  wire logic [31:0]           cpu_rdata,
  output logic                       cpu_halt_req,
  output logic                       cpu_go,
  output logic                       cpu_step,
  output logic                       erase_req
);
  import dcl_pkg::*;

  logic        sw_s1, sw_s2, sw_s3;     // Pin synchroniser and edge stage
  logic        fall;                    // Falling edge on the line
  dcl_state_t  state;                   // Sequencer state
  logic [7:0]  cnt;                     // Shared phase counter
  logic [4:0]  bcnt;                    // Cycle within a bit time
  logic        in_bit;                  // Receiving a bit time
  logic [5:0]  bits_left;               // Bits left in a field
  logic [31:0] rx_sh;                   // Receive shift register
  logic [39:0] tx_sh;                   // Transmit shift register
  logic [7:0]  lowcnt;                  // Length of the present low level
  logic [7:0]  opc;                     // Latched opcode
  dcl_kind_t   kind;                    // Latched command kind
  logic        legal;                   // Latched legality
  logic [5:0]  wbits, rbits;            // Latched field widths
  logic        p_addr, p_dly, p_ack, p_ss; // Latched structure
  logic [23:0] cur_addr;                // Sequential access address
  logic        seq_valid;               // Start address has been set
  logic [31:0] rd_data;                 // Data to return
  logic        op_busy;                 // Access outstanding
  logic        long_ack;                // Aborted access pending
  logic [9:0]  to_cnt;                  // Free-cycle wait counter
  // Control/status register
  logic        debug_enable_bit, cycle_select_a, hs_on, illegal_command_flag, no_response_flag;
  logic [7:0]  control_status_low_byte;
  logic        ill_set, nr_set, hs_on_set, hs_off_set, wcsr_we;
  logic [15:0] wcsr_data;
  // Decoder outputs
  dcl_class_t  d_class;
  dcl_kind_t   d_kind;
  logic [5:0]  d_wbits, d_rbits, d_n;
  logic        d_addr, d_dly, d_ack, d_ss, d_legal;
  logic        apb_wr;
  logic [31:0] tx_word;

  // Two flip-flops before the line is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_s1 <= 1'b1;
      sw_s2 <= 1'b1;
      sw_s3 <= 1'b1;
    end else begin
      sw_s1 <= single_wire_in;
      sw_s2 <= sw_s1;
      sw_s3 <= sw_s2;
    end
  end
  assign fall = sw_s3 & ~sw_s2;

  assign control_status_low_byte = {debug_enable_bit, cpu_halted, unsecure, hs_on,
                                    cycle_select_a, no_response_flag, 1'b0, illegal_command_flag};

  // Opcode decoder: class, kind and packet structure
  always_comb begin
    d_n     = (opc[3:2] == 2'b00) ? 6'd8 : (opc[3:2] == 2'b01) ? 6'd16 : 6'd32;
    d_class = C_NONE;
    d_kind  = K_BAD;
    d_addr  = 1'b0;
    d_wbits = 6'd0;
    d_rbits = 6'd0;
    d_dly   = 1'b1;
    d_ack   = 1'b1;
    d_ss    = 1'b0;
    if (opc == 8'h03) begin
      d_class = C_ALWAYS;
      d_kind  = K_ACKOFF;
      d_ack   = 1'b0;
    end else if (opc == 8'h02) begin
      d_class = C_ALWAYS;
      d_kind  = K_ACKON;
    end else if (opc == 8'h2d) begin
      d_class = C_ALWAYS;
      d_kind  = K_RCSR;
      d_dly   = 1'b0;
      d_rbits = 6'd16;
    end else if (opc == 8'h0d) begin
      d_class = C_ALWAYS;
      d_kind  = K_WCSR;
      d_dly   = 1'b0;
      d_wbits = 6'd16;
    end else if (opc == 8'h95) begin
      d_class = C_ALWAYS;
      d_kind  = K_ERASE;
      d_ack   = 1'b0;
    end else if (opc == 8'h00) begin
      d_class = C_NONINTR;
      d_kind  = K_NOP;
    end else if (opc == 8'h04) begin
      d_class = C_NONINTR;
      d_kind  = K_BGND;
    end else if (opc[7:4] == 4'h3 || opc[7:4] == 4'h1) begin
      d_class = C_NONINTR;
      d_ack   = ~opc[0];
      d_ss    = opc[0];
      if (opc[7:4] == 4'h3) begin
        d_kind  = opc[1] ? K_DUMP : K_RMEM;
        d_addr  = ~opc[1];
        d_rbits = d_n;
      end else begin
        d_kind  = opc[1] ? K_FILL : K_WMEM;
        d_addr  = ~opc[1];
        d_wbits = d_n;
      end
    end else if (opc[7:4] == 4'h5 && !opc[1]) begin
      d_class = C_NONINTR;
      d_kind  = K_RSAME;
      d_ack   = ~opc[0];
      d_ss    = opc[0];
      d_rbits = d_n;
    end else if (opc[7:4] == 4'h6 || opc[7:4] == 4'h4) begin
      d_class = C_ACTIVE;
      d_kind  = opc[5] ? K_RREG : K_WREG;
      d_rbits = opc[5] ? 6'd32 : 6'd0;
      d_wbits = opc[5] ? 6'd0 : 6'd32;
    end else if (opc == 8'h08 || opc == 8'h0c || opc == 8'h09) begin
      d_class = C_ACTIVE;
      d_kind  = (opc == 8'h09) ? K_STEP : K_GO;
    end
    // Class gate by security, enable and halt
    unique case (d_class)
      C_ALWAYS:  d_legal = 1'b1;
      C_NONINTR: d_legal = debug_enable_bit & unsecure;
      C_ACTIVE:  d_legal = debug_enable_bit & unsecure & cpu_halted;
      C_NONE:    d_legal = 1'b0;
    endcase
    if ((d_kind == K_DUMP || d_kind == K_FILL || d_kind == K_RSAME) && !seq_valid) begin
      d_legal = 1'b0;
    end
  end

  // Read data, left justified, 0xEE bytes when rejected
  always_comb begin
    if (!legal) begin
      tx_word = {4{`DCL_ILLEGAL_BYTE}};
    end else if (rbits == 6'd8) begin
      tx_word = {rd_data[7:0], 24'h000000};
    end else if (rbits == 6'd16) begin
      tx_word = {rd_data[15:0], 16'h0000};
    end else begin
      tx_word = rd_data;
    end
  end

  // Command sequencer: framing, delays, access and answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      cnt <= 8'h00;
      bcnt <= 5'h00;
      in_bit <= 1'b0;
      bits_left <= 6'h00;
      rx_sh <= 32'h00000000;
      tx_sh <= 40'h0000000000;
      lowcnt <= 8'h00;
      opc <= 8'h00;
      kind <= K_NOP;
      legal <= 1'b0;
      wbits <= 6'h00;
      rbits <= 6'h00;
      p_addr <= 1'b0;
      p_dly <= 1'b0;
      p_ack <= 1'b0;
      p_ss <= 1'b0;
      cur_addr <= 24'h000000;
      seq_valid <= 1'b0;
      rd_data <= 32'h00000000;
      op_busy <= 1'b0;
      long_ack <= 1'b0;
      to_cnt <= 10'h000;
      mem_req <= '0;
      cpu_req <= '0;
      cpu_halt_req <= 1'b0;
      cpu_go <= 1'b0;
      cpu_step <= 1'b0;
      erase_req <= 1'b0;
      single_wire_oe <= 1'b0;
      ill_set <= 1'b0;
      nr_set <= 1'b0;
      hs_on_set <= 1'b0;
      hs_off_set <= 1'b0;
      wcsr_we <= 1'b0;
      wcsr_data <= 16'h0000;
    end else begin
      // One-cycle pulses fall back each cycle
      cpu_halt_req <= 1'b0;
      cpu_go <= 1'b0;
      cpu_step <= 1'b0;
      erase_req <= 1'b0;
      ill_set <= 1'b0;
      nr_set <= 1'b0;
      hs_on_set <= 1'b0;
      hs_off_set <= 1'b0;
      wcsr_we <= 1'b0;
      // Measure host low time for speed sync; own pulses restart it
      lowcnt <= (sw_s2 || single_wire_oe) ? 8'h00 : ((lowcnt == 8'hff) ? lowcnt : lowcnt + 8'd1);
      // Bit receiver, 16 cycles per bit time; keeps counting through decode
      if (state == S_OPC || state == S_ADDR || state == S_WDATA || state == S_IDLE || state == S_DEC) begin
        if (fall && !in_bit) begin
          in_bit <= 1'b1;
          bcnt <= 5'd1;
          if (state == S_IDLE) begin
            state <= S_OPC;
            bits_left <= 6'd8;
          end
        end else if (in_bit) begin
          bcnt <= bcnt + 5'd1;
          if (bcnt == `DCL_SAMPLE_CYC) begin
            rx_sh <= {rx_sh[30:0], sw_s2};
          end
          if (bcnt == `DCL_BIT_CYC - 5'd1) begin
            in_bit <= 1'b0;
            bits_left <= bits_left - 6'd1;
          end
        end
      end
      if (lowcnt == `DCL_SYNC_MIN && state != S_SYNC_PULSE && !single_wire_oe) begin
        state <= S_SYNC_REL;
        in_bit <= 1'b0;
        op_busy <= 1'b0;
        mem_req.valid <= 1'b0;
        cpu_req.valid <= 1'b0;
      end else begin
        unique case (state)
          S_IDLE: begin
          end
          S_OPC: begin
            if (bits_left == 6'd0 && !in_bit) begin
              opc <= rx_sh[7:0];
              state <= S_DEC;
            end
          end
          S_DEC: begin
            kind <= d_kind;
            legal <= d_legal;
            wbits <= d_wbits;
            rbits <= d_rbits;
            p_addr <= d_addr;
            p_dly <= d_dly;
            p_ack <= d_ack;
            p_ss <= d_ss;
            ill_set <= ~d_legal;
            hs_on_set <= d_legal & (d_kind == K_ACKON);
            hs_off_set <= d_legal & (d_kind == K_ACKOFF);
            if (d_legal && (d_kind == K_DUMP || d_kind == K_FILL)) begin
              cur_addr <= cur_addr + {21'h000000, d_n[5:3]};
            end
            rd_data <= {16'h0000, control_status_low_byte, control_status_low_byte};
            cnt <= 8'h00;
            if (d_addr) begin
              state <= S_ADDR;
              bits_left <= 6'd24;
            end else if (d_wbits != 6'd0) begin
              state <= S_WDATA;
              bits_left <= d_wbits;
            end else if (d_dly) begin
              state <= S_DLY;
              op_busy <= d_legal;
            end else begin
              state <= S_TX;
              cnt <= 8'hff;
              bits_left <= d_rbits;
            end
          end
          S_ADDR: begin
            if (bits_left == 6'd0 && !in_bit) begin
              if (legal) begin
                cur_addr <= rx_sh[23:0];
                seq_valid <= 1'b1;
              end
              if (wbits != 6'd0) begin
                state <= S_WDATA;
                bits_left <= wbits;
              end else begin
                state <= S_DLY;
                op_busy <= legal;
              end
            end
          end
          S_WDATA: begin
            if (bits_left == 6'd0 && !in_bit) begin
              if (kind == K_WCSR) begin
                wcsr_we <= 1'b1;
                wcsr_data <= rx_sh[15:0];
                state <= S_IDLE;
              end else begin
                state <= S_DLY;
                op_busy <= legal;
              end
            end
          end
          S_DLY: begin
            cnt <= (cnt == 8'hff) ? cnt : cnt + 8'd1;
            if (op_busy) begin
              unique case (kind)
                K_RMEM, K_DUMP, K_RSAME, K_WMEM, K_FILL: begin
                  if (mem_req.valid) begin
                    if (mem_ack) begin
                      mem_req.valid <= 1'b0;
                      op_busy <= 1'b0;
                      rd_data <= mem_rdata;
                    end
                  end else if (hs_on && !cycle_select_a && !bus_free) begin
                    to_cnt <= to_cnt + 10'd1;
                    if (to_cnt == `DCL_CYCLE_SELECT_A_TIMEOUT - 10'd1) begin
                      op_busy <= 1'b0;
                      nr_set <= 1'b1;
                      long_ack <= 1'b1;
                    end
                  end else begin
                    mem_req.valid <= 1'b1;
                    mem_req.write <= (kind == K_WMEM || kind == K_FILL);
                    mem_req.size <= (opc[3:2] == 2'b11) ? 2'b10 : opc[3:2];
                    mem_req.addr <= cur_addr;
                    mem_req.wdata <= rx_sh;
                  end
                end
                K_RREG, K_WREG: begin
                  if (!cpu_req.valid) begin
                    cpu_req.valid <= 1'b1;
                    cpu_req.write <= (kind == K_WREG);
                    cpu_req.index <= opc[3:0];
                    cpu_req.wdata <= rx_sh;
                  end else if (cpu_ack) begin
                    cpu_req.valid <= 1'b0;
                    op_busy <= 1'b0;
                    rd_data <= cpu_rdata;
                  end
                end
                default: begin
                  cpu_halt_req <= (kind == K_BGND);
                  cpu_go <= (kind == K_GO);
                  cpu_step <= (kind == K_STEP);
                  erase_req <= (kind == K_ERASE);
                  op_busy <= 1'b0;
                end
              endcase
            end else if (cnt >= ((p_ack && hs_on) ? `DCL_DACK_CYC : `DCL_DLY_CYC) - 8'd1) begin
              to_cnt <= 10'h000;
              cnt <= 8'h00;
              if (p_ack && (hs_on || long_ack)) begin
                state <= S_ACK;
                single_wire_oe <= 1'b1;
              end else if (rbits != 6'd0 || p_ss) begin
                state <= S_TX;
                cnt <= 8'hff;
                bits_left <= rbits + (p_ss ? 6'd8 : 6'd0);
              end else begin
                state <= S_IDLE;
              end
            end
          end
          S_ACK: begin
            cnt <= cnt + 8'd1;
            if (cnt == (long_ack ? `DCL_LONG_ACK_CYC : `DCL_ACK_CYC) - 8'd1) begin
              single_wire_oe <= 1'b0;
              long_ack <= 1'b0;
              cnt <= 8'hff;
              bits_left <= rbits;
              state <= (rbits != 6'd0) ? S_TX : S_IDLE;
            end
          end
          S_TX: begin
            if (cnt == 8'hff) begin
              tx_sh <= p_ss ? {control_status_low_byte, tx_word} : {tx_word, 8'h00};
              cnt <= 8'h00;
            end else if (bits_left == 6'd0) begin
              state <= S_IDLE;
              single_wire_oe <= 1'b0;
            end else begin
              cnt <= (cnt == {3'b000, `DCL_BIT_CYC} - 8'd1) ? 8'h00 : cnt + 8'd1;
              single_wire_oe <= cnt[4:0] < (tx_sh[39] ? `DCL_TX_LOW1 : `DCL_TX_LOW0);
              if (cnt == {3'b000, `DCL_BIT_CYC} - 8'd1) begin
                tx_sh <= {tx_sh[38:0], 1'b0};
                bits_left <= bits_left - 6'd1;
              end
            end
          end
          S_SYNC_REL: begin
            cnt <= 8'h00;
            if (sw_s2) begin
              state <= S_SYNC_GAP;
            end
          end
          S_SYNC_GAP: begin
            cnt <= cnt + 8'd1;
            if (cnt == `DCL_DLY_CYC - 8'd1) begin
              cnt <= 8'h00;
              single_wire_oe <= 1'b1;
              state <= S_SYNC_PULSE;
            end
          end
          S_SYNC_PULSE: begin
            cnt <= cnt + 8'd1;
            if (cnt == `DCL_SYNC_PULSE - 8'd1) begin
              single_wire_oe <= 1'b0;
              state <= S_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign apb_wr = psel & penable & pwrite & pready;

  // Control/status register; a hardware set beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_enable_bit <= 1'b0;
      cycle_select_a <= 1'b0;
      hs_on <= 1'b0;
      illegal_command_flag <= 1'b0;
      no_response_flag <= 1'b0;
    end else begin
      if (hs_on_set) begin
        hs_on <= 1'b1;
      end else if (hs_off_set) begin
        hs_on <= 1'b0;
      end
      if (wcsr_we) begin
        debug_enable_bit <= wcsr_data[`DCL_CSR_ENABLE];
        cycle_select_a <= wcsr_data[`DCL_CSR_CYCLE_SELECT_A];
      end else if (apb_wr && paddr == `DCL_OFF_CSR) begin
        debug_enable_bit <= pwdata[`DCL_CSR_ENABLE];
        cycle_select_a <= pwdata[`DCL_CSR_CYCLE_SELECT_A];
      end
      illegal_command_flag <= ill_set | (illegal_command_flag &
        ~((wcsr_we & wcsr_data[`DCL_CSR_ILLEGAL]) | (apb_wr && paddr == `DCL_OFF_CSR && pwdata[`DCL_CSR_ILLEGAL])));
      no_response_flag <= nr_set | (no_response_flag &
        ~((wcsr_we & wcsr_data[`DCL_CSR_NO_RESPONSE_FLAG]) | (apb_wr && paddr == `DCL_OFF_CSR && pwdata[`DCL_CSR_NO_RESPONSE_FLAG])));
    end
  end

  // APB slave: answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr != `DCL_OFF_CSR) & (paddr != `DCL_OFF_STATE);
      if (psel && !penable) begin
        if (paddr == `DCL_OFF_CSR) begin
          prdata <= {24'h000000, control_status_low_byte};
        end else if (paddr == `DCL_OFF_STATE) begin
          prdata <= {16'h0000, opc, 2'b00, seq_valid, op_busy, state};
        end else begin
          prdata <= 32'h00000000;
        end
      end
    end
  end

  // Line is only ever pulled low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_wire_out <= 1'b0;
    end else begin
      single_wire_out <= 1'b0;
    end
  end
endmodule

// *** tb/dcl_host_model.sv ***
// Purpose: Debug host on the single-wire line.
// Assumes: Line has a pull-up; host pulls through host_low.
// Notes:   Bit is 16 cycles, low 4 for one, 13 for zero.
`timescale 1ns/1ps
module dcl_host_model (
  input  wire logic pclk,
  input  wire logic line,
  output logic      host_low
);
  initial host_low = 1'b0; // Released, line idles high
  // Send n bits from the top of v
  task automatic send(input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      for (int c = 0; c < 16; c++) begin
        host_low <= (c < (v[31 - i] ? 4 : 13));
        @(posedge pclk);
      end
    end
  endtask
  // Time the next low on the line, -1 if none comes
  task automatic get_low(output int len);
    int k;
    len = 0;
    for (k = 0; k < 3000 && line !== 1'b0; k++) @(posedge pclk);
    if (k == 3000) len = -1;
    while (len >= 0 && line === 1'b0 && len < 300) begin
      len++;
      @(posedge pclk);
    end
  endtask
  // Hold the line low for n cycles, then release it
  task automatic hold_low(input int n);
    host_low <= 1'b1;
    repeat (n) @(posedge pclk);
    host_low <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// *** tb/dcl_top_monitor.sv ***
// Purpose: Port checks for dcl_top.
// Assumes: One clock, presetn async active low.
// Notes:   Bound after the module.
`timescale 1ns/1ps
module dcl_top_monitor
  import dcl_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic [11:0]           paddr,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  single_wire_out,
  input wire logic                  unsecure,
  input wire logic                  cpu_halted,
  input wire dcl_pkg::dcl_mem_req_t mem_req,
  input wire logic                  mem_ack,
  input wire dcl_pkg::dcl_cpu_req_t cpu_req,
  input wire logic                  cpu_halt_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // APB answers once, straight after setup
  ready_setup_a: assert property (psel && !penable |=> pready) else $error("pready late");
  ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("stray pready");
  bad_addr_a: assert property (psel && !penable && paddr != 12'h000 && paddr != 12'h004 |=> pslverr)
    else $error("no pslverr");
  open_drain_a: assert property (single_wire_out == 1'b0) else $error("line driven high");
  mem_hold_a: assert property (mem_req.valid && !mem_ack |=> !mem_req.valid || $stable(mem_req.addr))
    else $error("request moved");
  mem_gate_a: assert property ($rose(mem_req.valid) |-> unsecure) else $error("secure access");
  cpu_gate_a: assert property ($rose(cpu_req.valid) |-> unsecure && cpu_halted) else $error("core not halted");
  halt_pulse_a: assert property (cpu_halt_req |=> !cpu_halt_req) else $error("halt pulse long");
endmodule
bind dcl_top dcl_top_monitor mon_u (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
  .single_wire_out, .unsecure, .cpu_halted, .mem_req, .mem_ack, .cpu_req, .cpu_halt_req);

// *** tb/dcl_top_tb_top.sv ***
// Purpose: Self-checking bench for dcl_top.
// Assumes: Host model on the line, bench on APB and buses.
// Notes:   Memory data is the address low byte xor 5a.
`timescale 1ns/1ps
module dcl_top_tb_top;
  import dcl_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, single_wire_in, single_wire_out;
  logic         single_wire_oe, unsecure, cpu_halted, bus_free, cpu_halt_req, cpu_go, cpu_step, erase_req;
  logic         host_low, cpu_ack, perr, mem_ack = 1'b0;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd, a, mem_rdata = 32'h0, cpu_rdata = 32'h5a5aa5a5;
  dcl_mem_req_t mem_req;
  dcl_cpu_req_t cpu_req;
  int           n_fail, num_checks, n_mem, n_oe, n_halt, n_er, n_step, len;
  assign single_wire_in = ~(host_low | single_wire_oe);
  assign cpu_ack = cpu_req.valid;
  dcl_host_model host_u (.pclk, .line(single_wire_in), .host_low);
  dcl_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .single_wire_in, .single_wire_out, .single_wire_oe, .unsecure, .cpu_halted, .bus_free, .mem_req,
    .mem_ack, .mem_rdata, .cpu_req, .cpu_ack, .cpu_rdata, .cpu_halt_req, .cpu_go, .cpu_step, .erase_req);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Memory answers a cycle late, only on a free bus; event counters
  always @(posedge pclk) begin
    mem_ack <= mem_req.valid && !mem_ack && bus_free;
    mem_rdata <= {4{mem_req.addr[7:0] ^ 8'h5a}};
    n_mem <= n_mem + ($rose(mem_req.valid) ? 1 : 0);
    n_oe <= n_oe + ($rose(single_wire_oe) ? 1 : 0);
    n_halt <= n_halt + (cpu_halt_req === 1'b1 ? 1 : 0);
    n_er <= n_er + (erase_req === 1'b1 ? 1 : 0);
    n_step <= n_step + (cpu_step === 1'b1 ? 1 : 0);
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    results();
  endtask
  // One APB transfer; read data lands in rd
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (k = 1; k < 50 && pready !== 1'b1; k++) @(posedge pclk);
    if (k >= 50) hang();
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Collect n device bits, short low is a one
  task automatic recv(input int n);
    rd = 32'h0;
    repeat (n) begin
      host_u.get_low(len);
      if (len < 0) hang();
      rd = {rd[30:0], len < 8};
    end
    // Let the last bit time run out before the host talks again
    repeat (16) @(posedge pclk);
  endtask
  task automatic cmd(input logic [31:0] v, input int n);
    host_u.send(v, n);
    repeat (16) @(posedge pclk);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, unsecure, cpu_halted} = '0;
    bus_free = 1'b1;
    presetn = 1'b0;
    a = 32'hf5ba;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped", {31'h0, perr}, 32'h1);
    cmd({8'h30, 24'h000123}, 32);
    recv(8);
    chk("secure_read", rd, 32'hee);
    apb(1'b0, 12'h000, 32'h0);
    chk("illegal_flag", rd, 32'h1);
    chk("no_access", n_mem, 0);
    cmd({8'h95, 24'h0}, 8);
    repeat (8) @(posedge pclk);
    chk("erase", n_er, 1);
    cmd({8'h02, 24'h0}, 8);
    host_u.get_low(len);
    chk("ack_len", len, 16);
    apb(1'b1, 12'h000, 32'h81);
    apb(1'b0, 12'h000, 32'h0);
    chk("csr_on", rd, 32'h90);
    len = n_oe;
    cmd({8'h03, 24'h0}, 8);
    repeat (40) @(posedge pclk);
    chk("no_ack", n_oe - len, 0);
    unsecure <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      a = lfsr(a);
      cmd({8'h30 + 8'(4 * s), a[23:0]}, 32);
      recv(s == 0 ? 8 : s == 1 ? 16 : 32);
      chk("read_sz", rd, {4{a[7:0] ^ 8'h5a}} >> (s == 0 ? 24 : s == 1 ? 16 : 0));
    end
    cmd({8'h3e, 24'h0}, 8);
    recv(32);
    chk("dump_next", rd, {4{(a[7:0] + 8'h4) ^ 8'h5a}});
    cmd({8'h04, 24'h0}, 8);
    repeat (20) @(posedge pclk);
    chk("halt", n_halt, 1);
    for (int h = 0; h < 2; h++) begin
      cpu_halted <= h[0];
      cmd({8'h60, 24'h0}, 8);
      recv(32);
      chk("core_reg", rd, h ? 32'h5a5aa5a5 : 32'heeeeeeee);
    end
    cmd({8'h09, 24'h0}, 8);
    repeat (8) @(posedge pclk);
    chk("step", n_step, 1);
    host_u.hold_low(160);
    host_u.get_low(len);
    chk("sync_len", len, 128);
    cmd({8'h02, 24'h0}, 8);
    host_u.get_low(len);
    bus_free <= 1'b0;
    cmd({8'h30, 24'h000040}, 32);
    host_u.get_low(len);
    chk("long_ack", len, 64);
    apb(1'b0, 12'h000, 32'h0);
    chk("no_resp", rd & 32'h4, 32'h4);
    results();
  end
endmodule
